// *** tb/lin_bus_node.sv ***
// Purpose: Other LIN node on the shared bus
// Assumes: Pull-up bus, wired AND with the block output
// Notes: Bit time in clk cycles
`timescale 1ns/1ps
module lin_bus_node #(
  parameter int BIT = 16
) (
  input wire logic clk,
  output logic bus_drive
);
  initial bus_drive = 1'b1;
  // Holds a level n cycles; 1 is the released bus
  task automatic hold(input logic v, input int n);
    bus_drive <= v;
    repeat (n) @(posedge clk);
  endtask : hold
  task automatic send_break(input int n);
    hold(1'b0, n);
    hold(1'b1, BIT);
  endtask : send_break
  // Start bit, LSB first, stop bit
  task automatic send_byte(input logic [7:0] b);
    hold(1'b0, BIT);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], BIT);
    end
    hold(1'b1, BIT);
  endtask : send_byte
endmodule : lin_bus_node

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the header assist
// Assumes: Bench plays software, timer and UART
// Notes: One task per scenario
`timescale 1ns/1ps
module tb_top;
  localparam int BIT = 16;
  localparam logic [11:0] CA = lin_pkg::CTRL_ADDR;
  localparam logic [11:0] FA = lin_pkg::FLAG_ADDR;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [3:0] sel = 4'h0;
  logic ack;
  logic node_drv;
  logic tx;
  logic tcs = 1'b0;
  logic tu = 1'b0;
  logic tin;
  logic irq;
  logic utx = 1'b1;
  logic uten = 1'b0;
  logic ul = 1'b0;
  logic urx;
  wire bus = node_drv & tx;
  int num_errors = 0;
  int samples_checked = 0;
  int irq_cnt = 0;
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) irq_cnt++;
  lin_bus_node #(.BIT(BIT)) node (.clk(clk), .bus_drive(node_drv));
  lin_header_assist DUT (.clk(clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .receive_pin(bus), .transmit_pin(tx), .timer_count_start(tcs),
    .timer_underflow(tu), .timer_in(tin), .timer_irq_req(irq), .uart_txd(utx),
    .uart_tx_enable(uten), .uart_latch(ul), .uart_rxd(urx));
  task automatic report_and_stop;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic wb(input logic w, input logic [3:0] sl, input logic [11:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sl;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk("ack", 8'h01, {7'h00, ack});
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
    @(posedge clk);
  endtask : wb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, 4'hF, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    wb(1'b0, 4'hF, a, 8'h00, q);
    chk(nm, e, q);
  endtask : rd
  task automatic t_reset;
    logic [7:0] q;
    rd(CA, lin_pkg::CTRL_RESET, "ctrl");
    rd(FA, lin_pkg::FLAG_RESET, "flags");
    wr(12'h000, 8'hFF);
    rd(12'h000, 8'h00, "unmapped");
    wb(1'b1, 4'hE, CA, 8'hFF, q);
    rd(CA, 8'h00, "ctrl kept");
    $display("test reset done");
  endtask : t_reset
  task automatic t_slave(input logic unmask_timing_select);
    int c;
    logic [7:0] m;
    m = {2'h2, unmask_timing_select, 5'h03};
    wr(CA, 8'h00);
    wr(CA, 8'h80);
    chk("rx block", 8'h01, {7'h00, urx});
    chk("timer block", 8'h01, {7'h00, tin});
    wr(CA, m | 8'h10);
    rd(CA, m | 8'h08, "armed ctrl");
    c = irq_cnt;
    fork
      node.send_break(40);
      begin
        step(30);
        tu <= 1'b1;
        step(1);
        tu <= 1'b0;
      end
    join
    rd(FA, 8'h01, "break flag");
    chk("break irq", 8'h01, 8'(irq_cnt - c));
    fork
      node.send_byte(8'h55);
      begin
        step(BIT * 4 + BIT / 2);
        chk("measuring", 8'h00, {7'h00, tin});
        chk("uart input", {7'h00, unmask_timing_select}, {7'h00, urx});
      end
    join
    rd(FA, 8'h03, "synch flag");
    chk("timer idle", 8'h01, {7'h00, tin});
    chk("synch irq", 8'h02, 8'(irq_cnt - c));
    rd(CA, m, "unblocked");
    wr(FA, 8'h03);
    rd(FA, 8'h00, "flags cleared");
    $display("test slave %0d done", unmask_timing_select);
  endtask : t_slave
  task automatic t_master;
    int c;
    wr(CA, 8'h00);
    wr(CA, 8'hC2);
    c = irq_cnt;
    tcs <= 1'b1;
    step(4);
    chk("break drive", 8'h00, {7'h00, tx});
    step(20);
    chk("break held", 8'h00, {7'h00, tx});
    tu <= 1'b1;
    step(1);
    tu <= 1'b0;
    step(3);
    chk("break end", 8'h01, {7'h00, tx});
    tcs <= 1'b0;
    rd(FA, 8'h01, "gen flag");
    chk("gen irq", 8'h01, 8'(irq_cnt - c));
    wr(FA, 8'h01);
    utx <= 1'b0;
    step(3);
    chk("uart path", 8'h00, {7'h00, tx});
    utx <= 1'b1;
    step(3);
    chk("uart path", 8'h01, {7'h00, tx});
    $display("test master done");
  endtask : t_master
  task automatic t_collision;
    int c;
    wr(CA, 8'h00);
    for (int en = 0; en < 2; en++) begin
      wr(CA, {5'h10, en[0], 2'h0});
      uten <= 1'b1;
      c = irq_cnt;
      node.hold(1'b0, 4);
      ul <= 1'b1;
      step(1);
      ul <= 1'b0;
      node.hold(1'b1, 4);
      uten <= 1'b0;
      rd(FA, 8'h04, "collision flag");
      chk("collision irq", 8'(en), 8'(irq_cnt - c));
      wr(FA, 8'h04);
    end
    $display("test collision done");
  endtask : t_collision
  task automatic t_halt;
    wr(CA, 8'h80);
    wr(CA, 8'h90);
    wr(CA, 8'h00);
    node.hold(1'b0, 5);
    chk("halt rx", 8'h00, {7'h00, urx});
    chk("halt timer", 8'h01, {7'h00, tin});
    node.hold(1'b1, 5);
    $display("test halt done");
  endtask : t_halt
  initial begin
    step(12);
    rst_n <= 1'b1;
    step(1);
    t_reset();
    t_slave(1'b0);
    t_slave(1'b1);
    t_master();
    t_collision();
    t_halt();
    report_and_stop();
  end
  initial begin
    #100000;
    num_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    report_and_stop();
  end
endmodule : tb_top

// *** verilog/lin_header_assist.sv ***
// Purpose: LIN header assist beside interval timer and UART
// Assumes: Timer and UART signals on clk; receive pin asynchronous
// Notes: Registers over classic Wishbone, 8 bits in lane 0
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module lin_header_assist (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [lin_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic receive_pin,
  output logic transmit_pin,
  input wire logic timer_count_start,
  input wire logic timer_underflow,
  output logic timer_in,
  output logic timer_irq_req,
  input wire logic uart_txd,
  input wire logic uart_tx_enable,
  input wire logic uart_latch,
  output logic uart_rxd
);
  typedef enum logic [2:0] {
    S_IDLE,
    S_BLOCKED,
    S_ARMED,
    S_SYNCH,
    S_MBREAK,
    S_PASS
  } hdr_state_t;

  typedef struct packed {
    hdr_state_t st;
    logic [7:0] ctrl;
    logic blocked;
    logic brk;
    logic syn;
    logic col;
    logic drive_low;
    logic tx;
    logic urx;
    logic tin;
    logic irq;
    logic ack;
    logic [7:0] rdata;
    logic rx_s1;
    logic rx_s2;
    logic rx_d;
    logic timer_count_start_d;
  } main_state_t;

  localparam main_state_t RST_S = '{
    st: S_IDLE,
    ctrl: lin_pkg::CTRL_RESET,
    default: '0
  };

  main_state_t s;
  main_state_t next_s;
  synch_meas_if meas ();

  synch_edge_counter u_cnt (
    .clk(clk),
    .rst_n(rst_n),
    .m(meas.cnt)
  );

  logic hit_ctrl;
  logic hit_flag;
  logic wr_ctrl;
  logic wr_flag;
  logic run;
  logic is_master;
  logic rx_low;
  logic brk_det;
  logic timer_count_start_rise;
  logic set_brk;
  logic set_syn;
  logic set_col;
  logic [7:0] wbyte;

  assign hit_ctrl = wb_adr_i[11:2] == lin_pkg::CTRL_ADDR[11:2];
  assign hit_flag = wb_adr_i[11:2] == lin_pkg::FLAG_ADDR[11:2];
  assign wbyte = wb_dat_i[7:0];
  // Writes land on the edge at which the master sees ack
  assign wr_ctrl = wb_cyc_i && wb_stb_i && s.ack && wb_we_i
                   && wb_sel_i[0] && hit_ctrl;
  assign wr_flag = wb_cyc_i && wb_stb_i && s.ack && wb_we_i
                   && wb_sel_i[0] && hit_flag;
  assign run = s.ctrl[lin_pkg::RUN_BIT];
  assign is_master = s.ctrl[lin_pkg::MASTER_BIT];
  assign rx_low = !s.rx_s2;
  assign timer_count_start_rise = timer_count_start && !s.timer_count_start_d;
  assign brk_det = run && !is_master && s.st == S_ARMED
                   && timer_underflow && rx_low;
  assign set_brk = brk_det || (s.st == S_MBREAK && timer_underflow && run);
  assign set_syn = run && s.st == S_SYNCH && meas.done;
  assign set_col = run && uart_tx_enable && uart_latch
                   && (s.rx_s2 != s.tx);
  assign meas.en = run && s.st == S_SYNCH;
  assign meas.fall = s.rx_d && !s.rx_s2;

  always_comb begin
    next_s = s;
    next_s.rx_s1 = receive_pin;
    next_s.rx_s2 = s.rx_s1;
    next_s.rx_d = s.rx_s2;
    next_s.timer_count_start_d = timer_count_start;
    next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
    next_s.irq = 1'b0;
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      if (hit_ctrl) begin
        next_s.rdata = s.ctrl;
        next_s.rdata[lin_pkg::BLK_BIT] = s.blocked; // R1
        next_s.rdata[lin_pkg::ARM_BIT] = 1'b0; // R2
      end else if (hit_flag) begin
        next_s.rdata = lin_pkg::FLAG_RESET;
        next_s.rdata[lin_pkg::BRK_BIT] = s.brk;
        next_s.rdata[lin_pkg::SYN_BIT] = s.syn;
        next_s.rdata[lin_pkg::COL_BIT] = s.col;
      end else begin
        next_s.rdata = 8'h00;
      end
    end
    if (wr_flag) begin
      if (wbyte[lin_pkg::BRK_BIT]) begin
        next_s.brk = 1'b0;
      end
      if (wbyte[lin_pkg::SYN_BIT]) begin
        next_s.syn = 1'b0;
      end
      if (wbyte[lin_pkg::COL_BIT]) begin
        next_s.col = 1'b0;
      end
    end
    // Header sequencing
    unique case (s.st)
      S_IDLE: begin
      end
      S_BLOCKED: begin
        if (is_master && timer_count_start_rise) begin
          next_s.st = S_MBREAK; // R9
          next_s.drive_low = 1'b1; // R9
        end
      end
      S_ARMED: begin
        if (brk_det) begin
          next_s.st = S_SYNCH; // R12
          if (!s.ctrl[lin_pkg::LATE_UNMASK_BIT]) begin
            next_s.blocked = 1'b0; // R3
          end
        end
      end
      S_SYNCH: begin
        if (meas.done) begin
          next_s.st = S_PASS;
          next_s.blocked = 1'b0; // R3 R16
        end
      end
      S_MBREAK: begin
        if (timer_underflow) begin
          next_s.st = S_PASS; // R10
          next_s.drive_low = 1'b0; // R10
          next_s.blocked = 1'b0; // R11
        end
      end
      S_PASS: begin
      end
    endcase
    if (wr_ctrl) begin
      next_s.ctrl = wbyte;
      next_s.ctrl[lin_pkg::BLK_BIT] = 1'b0;
      next_s.ctrl[lin_pkg::ARM_BIT] = 1'b0;
      if (wbyte[lin_pkg::RUN_BIT] && !run) begin
        next_s.st = S_BLOCKED; // R8
        next_s.blocked = 1'b1; // R8
      end else if (wbyte[lin_pkg::RUN_BIT] && wbyte[lin_pkg::ARM_BIT]) begin
        next_s.blocked = 1'b1; // R2
        next_s.drive_low = 1'b0;
        next_s.st = wbyte[lin_pkg::MASTER_BIT] ? S_BLOCKED : S_ARMED; // R4
      end
    end
    if (!run) begin
      next_s.st = S_IDLE; // R5
      next_s.blocked = 1'b0; // R5
      next_s.drive_low = 1'b0; // R5
      if (wr_ctrl && wbyte[lin_pkg::RUN_BIT]) begin
        next_s.st = S_BLOCKED; // R8
        next_s.blocked = 1'b1; // R8
      end
    end
    // Hardware set wins over a same-cycle clear
    if (set_brk) begin
      next_s.brk = 1'b1; // R10 R12 R20
    end
    if (set_syn) begin
      next_s.syn = 1'b1; // R14 R20
    end
    if (set_col) begin
      next_s.col = 1'b1; // R18 R20
    end
    next_s.irq = (set_brk && s.ctrl[lin_pkg::BRK_IE_BIT]) // R19
                 || (set_syn && s.ctrl[lin_pkg::SYN_IE_BIT]) // R14
                 || (set_col && s.ctrl[lin_pkg::COL_IE_BIT]); // R17
    // Master: timer output ORed as a low drive onto transmit
    next_s.tx = uart_txd && !(next_s.drive_low && is_master); // R4 R9
    next_s.urx = next_s.blocked ? 1'b1 : s.rx_s2; // R1
    if (next_s.st == S_SYNCH) begin
      next_s.tin = !(meas.busy || meas.fall); // R13
    end else if (next_s.st == S_ARMED) begin
      next_s.tin = s.rx_s2; // R2
    end else begin
      next_s.tin = 1'b1; // R8
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= RST_S;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = {24'h000000, s.rdata};
  assign transmit_pin = s.tx;
  assign uart_rxd = s.urx;
  assign timer_in = s.tin;
  assign timer_irq_req = s.irq;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence ctrl_read_ack;
    wb_ack_o && !wb_we_i && hit_ctrl;
  endsequence

  sequence master_go;
    run && is_master && s.st == S_BLOCKED && timer_count_start_rise;
  endsequence

  sequence master_end;
    s.st == S_MBREAK && timer_underflow && run;
  endsequence

  a_arm_reads_zero: assert property ( // R2
    ctrl_read_ack |-> wb_dat_o[lin_pkg::ARM_BIT] == 1'b0)
    else $error("Arm bit read back as one");

  a_blocked_status: assert property ( // R1
    wb_cyc_i && wb_stb_i && !s.ack && hit_ctrl && !wb_we_i
    |=> wb_dat_o[lin_pkg::BLK_BIT] == $past(s.blocked))
    else $error("Blocked flag read wrong");

  a_blocked_gates_rx: assert property ( // R1
    s.blocked |-> uart_rxd)
    else $error("Blocked receive reached UART");

  a_run_blocks: assert property ( // R8
    $rose(run) |-> s.blocked && s.st == S_BLOCKED ##1 timer_in && uart_rxd)
    else $error("Run start did not block inputs");

  a_halt_idle: assert property ( // R5
    !run && !wr_ctrl |=> s.st == S_IDLE && !s.drive_low && !meas.busy)
    else $error("Halted block still active");

  a_break_drive: assert property ( // R9
    master_go |=> s.drive_low ##1 !transmit_pin)
    else $error("Master break not driven low");

  a_break_end: assert property ( // R10
    master_end |=> !s.drive_low && s.brk && s.st == S_PASS)
    else $error("Master break end wrong");

  a_slave_break: assert property ( // R12
    brk_det |=> s.brk && s.st == S_SYNCH)
    else $error("Slave break not recognised");

  a_unmask_early: assert property ( // R3
    brk_det && !s.ctrl[lin_pkg::LATE_UNMASK_BIT] |=> !s.blocked)
    else $error("Unmask after break missed");

  a_unmask_late: assert property ( // R3
    brk_det && s.ctrl[lin_pkg::LATE_UNMASK_BIT] |=> s.blocked)
    else $error("Unmasked before synch measured");

  a_synch_flag: assert property ( // R14
    set_syn && s.ctrl[lin_pkg::SYN_IE_BIT] |=> s.syn && timer_irq_req)
    else $error("Synch flag or request missing");

  a_col_flag: assert property ( // R18
    set_col |=> s.col)
    else $error("Collision not flagged");

  a_col_irq_gate: assert property ( // R17
    set_col && !set_brk && !set_syn && !s.ctrl[lin_pkg::COL_IE_BIT]
    |=> !timer_irq_req)
    else $error("Masked collision raised request");

  a_flag_sticky: assert property ( // R20
    s.brk && !wr_flag |=> s.brk)
    else $error("Break flag lost without clear");
endmodule : lin_header_assist

// *** verilog/lin_pkg.sv ***
// Purpose: Constants for the LIN header-assist block
// Assumes: 32-bit classic Wishbone, 8-bit registers in byte lane 0
// Notes: Contract list below
// Contract
// R1: rx_blocked_flag shows receive pin blocked from UART
// R2: Arming routes receive pin to timer; reads zero
// R3: Slave unmask after break or after synch
// R4: Mode bit: 0 slave detector, 1 master drive
// R5: Clearing run bit halts everything
// R6: Software checks blocked flag before break arrives
// R7: Software stops run before changing mode
// R8: Setting run blocks timer and UART inputs
// R9: Master drives transmit low during timer period
// R10: Underflow releases transmit, sets break flag
// R11: UART then sends synch, identifier, response
// R12: Slave long low is break; starts synch measure
// R13: Timer measures start bit plus bits 0-6
// R14: Measure end sets synch flag, optional interrupt
// R15: Software reprograms baud rate from timer count
// R16: Response follows only after identifier received
// R17: Collision enable gates collision interrupt
// R18: Transmit/receive mismatch at latch sets collision
// R19: All requests share the timer interrupt line
// R20: Status flags stay set until software clears
package lin_pkg;
  localparam int ADR_W = 12;
  // Register index 106h, byte address four times it
  localparam logic [11:0] CTRL_IDX = 12'h106;
  localparam logic [11:0] FLAG_IDX = 12'h107;
  localparam logic [11:0] CTRL_ADDR = {CTRL_IDX[9:0], 2'h0};
  localparam logic [11:0] FLAG_ADDR = {FLAG_IDX[9:0], 2'h0};
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  // Control bits
  localparam int SYN_IE_BIT = 0;
  localparam int BRK_IE_BIT = 1;
  localparam int COL_IE_BIT = 2;
  localparam int BLK_BIT = 3;
  localparam int ARM_BIT = 4;
  localparam int LATE_UNMASK_BIT = 5;
  localparam int MASTER_BIT = 6;
  localparam int RUN_BIT = 7;
  // Flag bits, write 1 to clear
  localparam int BRK_BIT = 0;
  localparam int SYN_BIT = 1;
  localparam int COL_BIT = 2;
  // Falling edges from start bit to end of bit 6 of 55h
  localparam logic [2:0] SYNCH_FALLS = 3'h5;
endpackage : lin_pkg

// *** verilog/synch_edge_counter.sv ***
// Purpose: Counts synch byte falling edges to gate the timer
// Assumes: fall is a one-cycle pulse from synchronised input
// Notes: busy from first fall until last fall
`timescale 1ns/1ps
module synch_edge_counter (
  input wire logic clk,
  input wire logic rst_n,
  synch_meas_if.cnt m
);
  typedef struct packed {
    logic [2:0] cnt;
    logic busy;
    logic done;
  } cnt_state_t;
  cnt_state_t s;
  cnt_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (!m.en) begin
      next_s.cnt = 3'h0;
      next_s.busy = 1'b0;
    end else if (m.fall && !s.done) begin
      next_s.cnt = s.cnt + 3'h1;
      next_s.busy = 1'b1;
      if (s.cnt + 3'h1 == lin_pkg::SYNCH_FALLS) begin // R13
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign m.busy = s.busy;
  assign m.done = s.done;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_done_fifth_fall: assert property ( // R13
    m.en && m.fall && s.cnt == 3'h4 |=> m.done && !m.busy)
    else $error("Synch measure did not end on fifth fall");
endmodule : synch_edge_counter

// *** verilog/synch_meas_if.sv ***
// Purpose: Link between header logic and synch edge counter
// Assumes: Same clock on both sides
// Notes: en level, fall and done pulses
`timescale 1ns/1ps
interface synch_meas_if;
  logic en;
  logic fall;
  logic busy;
  logic done;
  modport ctl (output en, output fall, input busy, input done);
  modport cnt (input en, input fall, output busy, output done);
endinterface : synch_meas_if
